// ### logic/cssf_hang_timer.sv
// Watchdog that resets the serial engine when data is held low
`timescale 1ns/1ps
`default_nettype none
`include "cssf_params.svh"
module cssf_hang_timer #(
  parameter int HANG_CYCLES = `CSSF_HANG_CYCLES
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Events
  cssf_link_if.sink   link,
  // Timeout pulse
  output logic        timeout
);
  logic        active;
  logic [15:0] lowCount;

  // Runs from start to stop or timeout, restarted by each start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
    end else if (link.startCond) begin
      active <= 1'b1;
    end else if (link.stopCond || timeout) begin
      active <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowCount <= 16'h0000;
    end else if (link.startCond || !active || link.sdaLevel) begin
      lowCount <= 16'h0000;
    end else if (!timeout) begin
      lowCount <= lowCount + 16'h0001;
    end
  end

  assign timeout = active && (lowCount == 16'(HANG_CYCLES));
endmodule
`default_nettype wire

// ### logic/cssf_link_if.sv
// Bus events found on the sampled serial pins
`timescale 1ns/1ps
`default_nettype none
interface cssf_link_if;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic sdaLevel;
  modport src  (output sclRise, sclFall, startCond, stopCond, sdaLevel);
  modport sink (input  sclRise, sclFall, startCond, stopCond, sdaLevel);
endinterface
`default_nettype wire

// ### logic/cssf_params.svh
// Register map, field positions, reset values and timing counts
`ifndef CSSF_PARAMS_SVH
`define CSSF_PARAMS_SVH
// ****************************************
// Bus addressing
// ****************************************
`define CSSF_DEV_ADDR      7'h6A
`define CSSF_ADDR_STATUS   8'h00
`define CSSF_ADDR_FAULT    8'h01
`define CSSF_ADDR_THERM    8'h02
`define CSSF_UNMAPPED_VAL  8'hFF
// ****************************************
// Field positions
// ****************************************
`define CSSF_B_SHIP        5
`define CSSF_B_THERM_EN    7
// ****************************************
// Reset values
// ****************************************
`define CSSF_SHIP_RST      1'h0
`define CSSF_SYSON_RST     1'h1
`define CSSF_MASK_RST      4'h0
`define CSSF_THERM_EN_RST  1'h1
`define CSSF_THERM_LO_RST  4'h8
// ****************************************
// Timing
// ****************************************
`define CSSF_CLK_PERIOD_NS 20
`define CSSF_HANG_TIME_NS  50000
`define CSSF_HANG_CYCLES   (`CSSF_HANG_TIME_NS / `CSSF_CLK_PERIOD_NS)
`endif

// ### logic/cssf_pin_sync.sv
// Pin synchronisers and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none
module cssf_pin_sync (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Serial pins
  input  wire logic   sclIn,
  input  wire logic   sdaIn,
  // Events
  cssf_link_if.src    link
);
  logic sclMeta, sclQ, sclPrev;
  logic sdaMeta, sdaQ, sdaPrev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclMeta <= 1'b1;
      sclQ    <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaQ    <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclQ    <= sclMeta;
      sclPrev <= sclQ;
      sdaMeta <= sdaIn;
      sdaQ    <= sdaMeta;
      sdaPrev <= sdaQ;
    end
  end

  assign link.sclRise   = sclQ & ~sclPrev;
  assign link.sclFall   = ~sclQ & sclPrev;
  assign link.startCond = sclQ & sclPrev & sdaPrev & ~sdaQ;
  assign link.stopCond  = sclQ & sclPrev & ~sdaPrev & sdaQ;
  assign link.sdaLevel  = sdaQ;
endmodule
`default_nettype wire

// ### logic/cssf_pkg.sv
// Types shared by the status and fault register block
`default_nettype none
package cssf_pkg;
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_RX_REG   = 4'h3,
    ST_ACK_REG  = 4'h4,
    ST_RX_DATA  = 4'h5,
    ST_ACK_DATA = 4'h6,
    ST_TX       = 4'h7,
    ST_ACK_TX   = 4'h8
  } cssf_state_t;
endpackage
`default_nettype wire

// ### logic/cssf_top.sv
// Status, fault and mask registers behind a serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "cssf_params.svh"
module cssf_top
  import cssf_pkg::*;
#(
  parameter int HANG_CYCLES = `CSSF_HANG_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Serial pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Chip disable pin
  input  wire logic       chipDisablePin,
  // Charger status
  input  wire logic [1:0] chargeState,
  input  wire logic       inputPowerMgmtActive,
  input  wire logic       systemSwitchOn,
  input  wire logic [1:0] thermalFault,
  // Fault sources
  input  wire logic       pbResetEvent,
  input  wire logic       timerExpired,
  input  wire logic       inputOvLevel,
  input  wire logic       inputUvEvent,
  input  wire logic       batLockoutLevel,
  input  wire logic       batOvercurrentEvent,
  // Controls
  output logic            shipRequest,
  output logic            thermalEnable,
  output logic [3:0]      thermalCtrl,
  output logic [3:0]      faultMask,
  output logic            faultNotify
);
  cssf_link_if link ();
  cssf_state_t state;
  logic       timeout;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [7:0] regPtr;
  logic [7:0] readValue;
  logic       readWrite;
  logic       masterAck;
  logic       readLoad;
  logic       wrStrobe;
  logic       cdMeta, cdQ, cdPrev;
  logic       cdToggle;
  logic       sysOn;
  logic       resetFault, timerFault;
  logic       ovFlag, uvFlag, lockFlag, ocFlag;
  logic       clrStatus, clrFault;

  cssf_pin_sync u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .link  (link.src)
  );

  cssf_hang_timer #(.HANG_CYCLES(HANG_CYCLES)) u_hang (
    .clk     (clk),
    .nrst    (nrst),
    .link    (link.sink),
    .timeout (timeout)
  );

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic isAddr(input logic [7:0] p, input logic [7:0] a);
    return p == a;
  endfunction

  always_comb begin
    if (isAddr(regPtr, `CSSF_ADDR_STATUS)) begin
      readValue = {chargeState, 1'b0, resetFault, timerFault,
                   inputPowerMgmtActive, cdQ, sysOn};
    end else if (isAddr(regPtr, `CSSF_ADDR_FAULT)) begin
      readValue = {ovFlag, uvFlag, lockFlag, ocFlag, faultMask};
    end else if (isAddr(regPtr, `CSSF_ADDR_THERM)) begin
      readValue = {thermalEnable, thermalFault, 1'b0, thermalCtrl};
    end else begin
      readValue = `CSSF_UNMAPPED_VAL;
    end
  end

  assign clrStatus = readLoad && isAddr(regPtr, `CSSF_ADDR_STATUS);
  assign clrFault  = readLoad && isAddr(regPtr, `CSSF_ADDR_FAULT);

  // ****************************************
  // Serial engine
  // ****************************************
  assign readLoad = link.sclFall && ((state == ST_ACK_ADDR && readWrite) ||
                    (state == ST_ACK_TX && masterAck));
  assign wrStrobe = link.sclFall && state == ST_RX_DATA && bitCnt == 4'h8;
  assign sdaOut   = 1'b0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      rxShift   <= 8'h00;
      txShift   <= 8'h00;
      regPtr    <= 8'h00;
      readWrite <= 1'b0;
      masterAck <= 1'b0;
      sdaOe     <= 1'b0;
    end else if (timeout || link.stopCond) begin
      state  <= ST_IDLE;
      sdaOe  <= 1'b0;
    end else if (link.startCond) begin
      state  <= ST_ADDR;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else if (link.sclRise) begin
      case (state)
        ST_ADDR, ST_RX_REG, ST_RX_DATA: begin
          rxShift <= {rxShift[6:0], link.sdaLevel};
          bitCnt  <= bitCnt + 4'h1;
        end
        ST_ACK_TX: begin
          masterAck <= ~link.sdaLevel;
        end
        default: begin
        end
      endcase
    end else if (link.sclFall) begin
      case (state)
        ST_ADDR: begin
          if (bitCnt == 4'h8 && rxShift[7:1] == `CSSF_DEV_ADDR) begin
            readWrite <= rxShift[0];
            sdaOe     <= 1'b1;
            state     <= ST_ACK_ADDR;
          end else if (bitCnt == 4'h8) begin
            state <= ST_IDLE;
          end
        end
        ST_ACK_ADDR, ST_ACK_TX: begin
          bitCnt <= 4'h0;
          if (readLoad) begin
            // Pointer moves past the byte just loaded and cleared
            regPtr  <= regPtr + 8'h01;
            txShift <= readValue;
            sdaOe   <= ~readValue[7];
            state   <= ST_TX;
          end else if (state == ST_ACK_ADDR) begin
            sdaOe <= 1'b0;
            state <= ST_RX_REG;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_RX_REG: begin
          if (bitCnt == 4'h8) begin
            regPtr <= rxShift;
            sdaOe  <= 1'b1;
            state  <= ST_ACK_REG;
          end
        end
        ST_ACK_REG, ST_ACK_DATA: begin
          if (state == ST_ACK_DATA) begin
            regPtr <= regPtr + 8'h01;
          end
          bitCnt <= 4'h0;
          sdaOe  <= 1'b0;
          state  <= ST_RX_DATA;
        end
        ST_RX_DATA: begin
          if (bitCnt == 4'h8) begin
            sdaOe <= 1'b1;
            state <= ST_ACK_DATA;
          end
        end
        ST_TX: begin
          bitCnt  <= bitCnt + 4'h1;
          txShift <= {txShift[6:0], 1'b0};
          if (bitCnt == 4'h7) begin
            sdaOe <= 1'b0;
            state <= ST_ACK_TX;
          end else begin
            sdaOe <= ~txShift[6];
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Writable fields
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shipRequest   <= `CSSF_SHIP_RST;
      faultMask     <= `CSSF_MASK_RST;
      thermalEnable <= `CSSF_THERM_EN_RST;
      thermalCtrl   <= `CSSF_THERM_LO_RST;
    end else if (wrStrobe) begin
      if (isAddr(regPtr, `CSSF_ADDR_STATUS)) begin
        shipRequest <= rxShift[`CSSF_B_SHIP];
      end
      if (isAddr(regPtr, `CSSF_ADDR_FAULT)) begin
        faultMask <= rxShift[3:0];
      end
      if (isAddr(regPtr, `CSSF_ADDR_THERM)) begin
        thermalEnable <= rxShift[`CSSF_B_THERM_EN];
        thermalCtrl   <= rxShift[3:0];
      end
    end
  end

  // ****************************************
  // Chip disable pin and system switch
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cdMeta <= 1'b0;
      cdQ    <= 1'b0;
      cdPrev <= 1'b0;
      sysOn  <= `CSSF_SYSON_RST;
    end else begin
      cdMeta <= chipDisablePin;
      cdQ    <= cdMeta;
      cdPrev <= cdQ;
      sysOn  <= systemSwitchOn;
    end
  end

  assign cdToggle = cdQ ^ cdPrev;

  // ****************************************
  // Status and fault flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resetFault <= 1'b0;
      timerFault <= 1'b0;
    end else begin
      resetFault <= pbResetEvent | (resetFault & ~clrStatus);
      timerFault <= timerExpired | (timerFault & ~cdToggle);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovFlag   <= 1'b0;
      uvFlag   <= 1'b0;
      lockFlag <= 1'b0;
      ocFlag   <= 1'b0;
    end else begin
      ovFlag   <= inputOvLevel | (ovFlag & ~clrFault);
      uvFlag   <= inputUvEvent | (uvFlag & ~clrFault);
      lockFlag <= batLockoutLevel | (lockFlag & ~clrFault);
      ocFlag   <= batOvercurrentEvent | (ocFlag & ~clrFault);
    end
  end

  // Notify while any fault flag is set whose mask bit is clear
  assign faultNotify = |({ovFlag, uvFlag, lockFlag, ocFlag} & ~faultMask);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_fault_read_quiet;
    clrFault && !inputUvEvent;
  endsequence

  sequence s_no_uv_2;
    !inputUvEvent [*2];
  endsequence

  a_state_live: assert property (
    isAddr(regPtr, `CSSF_ADDR_STATUS) |-> readValue[7:6] == chargeState)
    else $error("charge state not live");

  a_ship_write: assert property (
    wrStrobe && isAddr(regPtr, `CSSF_ADDR_STATUS)
      |=> shipRequest == $past(rxShift[5]))
    else $error("ship request not written");

  a_reset_clear: assert property (
    clrStatus && !pbResetEvent |=> !resetFault)
    else $error("reset flag not cleared by read");

  a_timer_hold: assert property (
    timerFault && !cdToggle && clrStatus |=> timerFault)
    else $error("timer fault lost without pin toggle");

  a_status_bits: assert property (
    isAddr(regPtr, `CSSF_ADDR_STATUS) |-> !readValue[5] && readValue[0] == sysOn)
    else $error("status layout wrong");

  a_ov_persist: assert property (
    inputOvLevel |=> ovFlag)
    else $error("overvoltage flag dropped");

  a_uv_once: assert property (
    s_fault_read_quiet ##1 s_no_uv_2 |-> !uvFlag)
    else $error("undervoltage flag not cleared");

  a_oc_clear: assert property (
    clrFault && !batOvercurrentEvent |=> !ocFlag)
    else $error("overcurrent flag not cleared");

  a_unmapped: assert property (
    regPtr > `CSSF_ADDR_THERM |-> readValue == `CSSF_UNMAPPED_VAL)
    else $error("unmapped read not all ones");

  a_hang_reset: assert property (
    timeout |=> state == ST_IDLE && !sdaOe)
    else $error("engine not reset on hang");

  a_mask_notify: assert property (
    faultMask == 4'hF |-> !faultNotify ##1 (faultMask != 4'hF || !faultNotify))
    else $error("masked fault notified");
endmodule
`default_nettype wire

// ### verif/cssf_host_model.sv
// Serial bus master model playing the host side of the registers
`timescale 1ns/1ps
`default_nettype none
`include "cssf_params.svh"
module cssf_host_model (
  // Clock
  input  wire logic clk,
  // Bus lines, sdaRel high lets the pull-up win
  output logic      scl,
  output logic      sdaRel,
  input  wire logic sdaWire
);
  // ****************************************
  // Bit cycles, clock idles high between frames
  // ****************************************
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put_bit(input logic b, output logic s);
    sdaRel <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    @(negedge clk) s = sdaWire;
    @(posedge clk) scl <= 1'b0;
    tick(1);
  endtask
  task automatic start();
    sdaRel <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaRel <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sdaRel <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaRel <= 1'b1;
    tick(4);
  endtask
  // ****************************************
  // Byte and register transfers
  // ****************************************
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(1'b1, s);
  endtask
  task automatic write_reg(input logic [7:0] a, d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({`CSSF_DEV_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    put_byte({`CSSF_DEV_ADDR, 1'b0}, k);
    put_byte(a, k);
    start();
    put_byte({`CSSF_DEV_ADDR, 1'b1}, k);
    get_byte(d);
    stop();
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the status and fault register block
`timescale 1ns/1ps
`default_nettype none
`include "cssf_params.svh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nErrors++; \
  $display("Error at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       clk, nrst, chipDisablePin, scl, sdaRel, sdaOut, sdaOe;
  logic [1:0] chargeState, thermalFault;
  logic       inputPowerMgmtActive, systemSwitchOn;
  logic       pbResetEvent, timerExpired, inputOvLevel, inputUvEvent;
  logic       batLockoutLevel, batOvercurrentEvent;
  logic       shipRequest, thermalEnable, faultNotify;
  logic [3:0] thermalCtrl, faultMask;
  int         nErrors, numChecks;
  wire        sdaWire = sdaRel & ~(sdaOe & ~sdaOut);
  cssf_top #(.HANG_CYCLES(400)) u_dut (
    .clk, .nrst, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOe,
    .chipDisablePin, .chargeState, .inputPowerMgmtActive,
    .systemSwitchOn, .thermalFault, .pbResetEvent, .timerExpired,
    .inputOvLevel, .inputUvEvent, .batLockoutLevel,
    .batOvercurrentEvent, .shipRequest, .thermalEnable, .thermalCtrl,
    .faultMask, .faultNotify
  );
  cssf_host_model u_host (.clk, .scl, .sdaRel, .sdaWire);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    u_host.read_reg(a, d);
    `CHK(d, e)
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic k;
    u_host.write_reg(a, d, k);
    `CHK(k, 1'b1)
  endtask
  function automatic logic [7:0] st0(input logic p, t);
    return {chargeState, 1'b0, p, t, inputPowerMgmtActive,
            chipDisablePin, systemSwitchOn};
  endfunction
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(shipRequest, 1'b0)
    `CHK({thermalEnable, thermalCtrl}, 5'h18)
    `CHK(faultMask, 4'h0)
    rd(`CSSF_ADDR_STATUS, 8'h01);
    rd(`CSSF_ADDR_FAULT, 8'h00);
    rd(`CSSF_ADDR_THERM, 8'hE8);
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      chargeState <= 2'(i);
      inputPowerMgmtActive <= i[0];
      systemSwitchOn <= i[1];
      tk(1);
      rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b0));
    end
    // Fault register reads all zero with no flag set and no mask
    rd(`CSSF_ADDR_FAULT, 8'h00);
  endtask
  task automatic t_ship();
    wr(`CSSF_ADDR_STATUS, 8'hFF);
    `CHK(shipRequest, 1'b1)
    rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b0));
    wr(`CSSF_ADDR_STATUS, 8'h00);
    `CHK(shipRequest, 1'b0)
  endtask
  task automatic t_clear();
    @(posedge clk);
    pbResetEvent <= 1'b1;
    inputUvEvent <= 1'b1;
    batOvercurrentEvent <= 1'b1;
    @(posedge clk);
    pbResetEvent <= 1'b0;
    inputUvEvent <= 1'b0;
    batOvercurrentEvent <= 1'b0;
    rd(`CSSF_ADDR_STATUS, st0(1'b1, 1'b0));
    rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b0));
    rd(`CSSF_ADDR_FAULT, 8'h50);
    rd(`CSSF_ADDR_FAULT, 8'h00);
  endtask
  task automatic t_persist();
    @(posedge clk);
    timerExpired <= 1'b1;
    inputOvLevel <= 1'b1;
    batLockoutLevel <= 1'b1;
    @(posedge clk);
    timerExpired <= 1'b0;
    rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b1));
    rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b1));
    @(posedge clk);
    chipDisablePin <= 1'b1;
    tk(4);
    rd(`CSSF_ADDR_STATUS, st0(1'b0, 1'b0));
    rd(`CSSF_ADDR_FAULT, 8'hA0);
    rd(`CSSF_ADDR_FAULT, 8'hA0);
  endtask
  task automatic t_mask();
    wr(`CSSF_ADDR_FAULT, 8'h0F);
    `CHK(faultMask, 4'hF)
    `CHK(faultNotify, 1'b0)
    rd(`CSSF_ADDR_FAULT, 8'hAF);
    wr(`CSSF_ADDR_FAULT, 8'h07);
    `CHK(faultNotify, 1'b1)
    wr(`CSSF_ADDR_FAULT, 8'h0D);
    `CHK(faultNotify, 1'b1)
    wr(`CSSF_ADDR_FAULT, 8'h0A);
    `CHK(faultNotify, 1'b0)
    @(posedge clk);
    inputOvLevel <= 1'b0;
    batLockoutLevel <= 1'b0;
    rd(`CSSF_ADDR_FAULT, 8'hAA);
    rd(`CSSF_ADDR_FAULT, 8'h0A);
  endtask
  task automatic t_map();
    rd(8'h05, `CSSF_UNMAPPED_VAL);
    rd(8'hFF, `CSSF_UNMAPPED_VAL);
    wr(`CSSF_ADDR_THERM, 8'h75);
    `CHK({thermalEnable, thermalCtrl}, 5'h05)
    rd(`CSSF_ADDR_THERM, 8'h65);
    thermalFault <= 2'b01;
    rd(`CSSF_ADDR_THERM, 8'h25);
  endtask
  task automatic t_hang();
    logic k, s;
    u_host.start();
    u_host.put_byte({`CSSF_DEV_ADDR, 1'b0}, k);
    u_host.put_byte(`CSSF_ADDR_FAULT, k);
    // Data held low mid-byte, the rest of the byte must be ignored
    u_host.put_bit(1'b0, s);
    u_host.tick(500);
    for (int i = 0; i < 8; i++) u_host.put_bit(i == 7, s);
    `CHK(s, 1'b1)
    u_host.stop();
    `CHK(faultMask, 4'hA)
    rd(`CSSF_ADDR_FAULT, 8'h0A);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    nrst = 1'b0;
    chipDisablePin = 1'b0;
    chargeState = 2'b00;
    inputPowerMgmtActive = 1'b0;
    systemSwitchOn = 1'b1;
    thermalFault = 2'b11;
    {pbResetEvent, timerExpired, inputOvLevel, inputUvEvent} = 4'h0;
    {batLockoutLevel, batOvercurrentEvent} = 2'b00;
    nErrors = 0;
    numChecks = 0;
    tk(6);
    nrst <= 1'b1;
    tk(3);
    t_reset();
    t_status();
    t_ship();
    t_clear();
    t_persist();
    t_mask();
    t_map();
    t_hang();
    tally_and_finish();
  end
  initial begin
    tk(50000);
    nErrors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
